// File: logic/dmrb_pkg.sv
// package for the dram mode register bank, addresses 06h to 0bh
package dmrb_pkg;
  // mode addresses
  localparam logic [5:0] ADDR_REV_FIRST  = 6'h06;
  localparam logic [5:0] ADDR_REV_SECOND = 6'h07;
  localparam logic [5:0] ADDR_DEV_INFO   = 6'h08;
  localparam logic [5:0] ADDR_VEND_TEST  = 6'h09;
  localparam logic [5:0] ADDR_CAL_RESET  = 6'h0A;
  localparam logic [5:0] ADDR_TERM_CTRL  = 6'h0B;
  // field positions
  localparam int CAL_RESET_BIT = 0;
  localparam int DQ_TERM_LSB   = 0;
  localparam int CA_TERM_LSB   = 4;
  localparam int TYPE_LSB      = 0;
  localparam int DENSITY_LSB   = 2;
  localparam int WIDTH_LSB     = 6;
  // reset values and the reserved termination code
  localparam logic [2:0] TERM_RESET     = 3'h0;
  localparam logic [2:0] TERM_RESERVED  = 3'h7;
  localparam logic [7:0] VEND_RESET     = 8'h00;
  localparam logic [7:0] READ_ZERO      = 8'h00;
  // identity values, arbitrary neutral choices
  localparam logic [7:0] REV_FIRST_DEF  = 8'h5A;
  localparam logic [7:0] REV_SECOND_DEF = 8'hA5;
  // device information defaults: low supply type, 4 Gb die, sixteen bits
  localparam logic [1:0] TYPE_DEF       = 2'h1;
  localparam logic [3:0] DENSITY_DEF    = 4'h0;
  localparam logic [1:0] WIDTH_DEF      = 2'h0;
  // length of the calibration reset pulse in cycles
  localparam int CAL_PULSE_CYCLES = 1;
endpackage

// File: logic/dmrb_mode_registers.sv
// mode register bank for identifiers, calibration reset and termination
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - address 06h reads first revision identifier
// - address 07h reads second revision identifier
// - info bits 1:0 report device type
// - info bits 5:2 report die density
// - info bits 7:6 report I/O width
// - calibration register bit 0 resets calibration
// - grounded pin: default calibration, commands ignored
// - termination bits 2:0 select data termination
// - termination bits 6:4 select command termination
// - writes update only write set point copy
// - operating set point copy drives termination
// - read drives operand bits, zeros elsewhere
module dmrb_mode_registers
  import dmrb_pkg::*;
#(
  parameter logic [7:0] REV_FIRST  = REV_FIRST_DEF,
  parameter logic [7:0] REV_SECOND = REV_SECOND_DEF
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clkEn,
  input  wire logic       modeRegWriteCmd,
  input  wire logic       modeRegReadCmd,
  input  wire logic [5:0] modeAddress,
  input  wire logic [7:0] operandBits,
  input  wire logic       writeSetPointSelect,
  input  wire logic       operatingSetPointSelect,
  input  wire logic       calPinGrounded,
  input  wire logic       calCommand,
  input  wire logic [1:0] devType,
  input  wire logic [3:0] devDensity,
  input  wire logic [1:0] devWidth,
  output logic      [7:0] readData,
  output logic            readValid,
  output logic            calResetPulse,
  output logic            calStartPulse,
  output logic            calDefaultMode,
  output logic      [2:0] dataBusTermination,
  output logic      [2:0] commandBusTermination,
  output logic      [7:0] vendorTest
);

  // read source picked by the address decode
  typedef enum logic [2:0] {
    RSEL_ZERO   = 3'h0,
    RSEL_REV1   = 3'h1,
    RSEL_REV2   = 3'h2,
    RSEL_INFO   = 3'h3,
    RSEL_VENDOR = 3'h4
  } dmrb_rsel_t;

  // two copies of each termination field, indexed by set point
  logic [2:0] dqTermSp_q [2];
  logic [2:0] caTermSp_q [2];

  // termination codes applied at the receivers
  logic [2:0] dqTermOut_q;
  logic [2:0] caTermOut_q;

  // last byte written to the vendor test address
  logic [7:0] vendorTest_q;

  // calibration pulses, pulse length count and mode
  logic       calReset_q;
  logic [3:0] calResetCnt_q;
  logic       calStart_q;
  logic       calDefault_q;

  // registered read answer and its strobe
  logic [7:0] readData_q;
  logic       readValid_q;

  // read byte and its source for the presented address
  logic [7:0] readData_d;
  dmrb_rsel_t readSel;

  // write strobes, one per writable address
  logic       wrVendTest;
  logic       wrCalReset;
  logic       wrTerm;

  // qualified calibration reset and calibration command
  logic       calResetReq;
  logic       calCmdTaken;

  // true when the presented address names the given register
  function automatic logic addrHit(input logic [5:0] a, input logic [5:0] target);
    return a == target;
  endfunction

  // one three-bit termination field of the operand byte
  function automatic logic [2:0] termField(input logic [7:0] op, input int lsb);
    return op[lsb +: 3];
  endfunction

  // device information byte from straps
  function automatic logic [7:0] devInfo(input logic [1:0] t, input logic [3:0] d,
                                         input logic [1:0] w);
    logic [7:0] v;
    v = READ_ZERO;
    v[TYPE_LSB +: 2]    = t;
    v[DENSITY_LSB +: 4] = d;
    v[WIDTH_LSB +: 2]   = w;
    return v;
  endfunction

  // filter a reserved termination code down to disabled
  function automatic logic [2:0] termCode(input logic [2:0] c);
    return (c == TERM_RESERVED) ? TERM_RESET : c;
  endfunction

  // write address decode; read-only and unknown addresses strobe nothing
  always_comb begin
    wrVendTest = 1'h0;
    wrCalReset = 1'h0;
    wrTerm     = 1'h0;
    if (!modeRegWriteCmd) begin
      wrTerm = 1'h0; // no write this cycle
    end else if (addrHit(modeAddress, ADDR_VEND_TEST)) begin
      wrVendTest = 1'h1;
    end else if (addrHit(modeAddress, ADDR_CAL_RESET)) begin
      wrCalReset = 1'h1;
    end else if (addrHit(modeAddress, ADDR_TERM_CTRL)) begin
      wrTerm = 1'h1;
    end else if (addrHit(modeAddress, ADDR_REV_FIRST) || addrHit(modeAddress, ADDR_REV_SECOND)
                 || addrHit(modeAddress, ADDR_DEV_INFO)) begin
      wrTerm = 1'h0;
    end else begin
      wrTerm = 1'h0; // unknown address, dropped
    end
  end

  // calibration reset asked for by operand bit 0
  assign calResetReq = wrCalReset && operandBits[CAL_RESET_BIT];

  // calibration command let through only with the reference resistor fitted
  assign calCmdTaken = calCommand && !calPinGrounded;

  // data-bus termination copies; only the write set point copy moves
  always_ff @(posedge clk) begin
    if (rst) begin
      dqTermSp_q[0] <= TERM_RESET;
      dqTermSp_q[1] <= TERM_RESET;
    end else if (clkEn && wrTerm) begin
      dqTermSp_q[writeSetPointSelect] <= termField(operandBits, DQ_TERM_LSB);
    end
  end

  // command-bus termination copies; only the write set point copy moves
  always_ff @(posedge clk) begin
    if (rst) begin
      caTermSp_q[0] <= TERM_RESET;
      caTermSp_q[1] <= TERM_RESET;
    end else if (clkEn && wrTerm) begin
      caTermSp_q[writeSetPointSelect] <= termField(operandBits, CA_TERM_LSB);
    end
  end

  // data-bus termination applied from the operating set point copy only
  always_ff @(posedge clk) begin
    if (rst) begin
      dqTermOut_q <= TERM_RESET;
    end else if (clkEn) begin
      dqTermOut_q <= termCode(dqTermSp_q[operatingSetPointSelect]);
    end
  end

  // command-bus termination applied from the operating set point copy only
  always_ff @(posedge clk) begin
    if (rst) begin
      caTermOut_q <= TERM_RESET;
    end else if (clkEn) begin
      caTermOut_q <= termCode(caTermSp_q[operatingSetPointSelect]);
    end
  end

  // vendor test register, expected to hold 00h
  always_ff @(posedge clk) begin
    if (rst) begin
      vendorTest_q <= VEND_RESET;
    end else if (clkEn && wrVendTest) begin
      vendorTest_q <= operandBits;
    end
  end

  // cycles left in the calibration reset pulse
  always_ff @(posedge clk) begin
    if (rst) begin
      calResetCnt_q <= 4'h0;
    end else if (clkEn) begin
      if (calResetReq) begin
        calResetCnt_q <= 4'(CAL_PULSE_CYCLES);
      end else if (calResetCnt_q != 4'h0) begin
        calResetCnt_q <= calResetCnt_q - 4'h1;
      end
    end
  end

  // calibration reset pulse, held for the programmed number of cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      calReset_q <= 1'h0;
    end else if (clkEn) begin
      calReset_q <= calResetReq || (calResetCnt_q > 4'h1);
    end
  end

  // calibration start pulse, dropped while the pin is grounded
  always_ff @(posedge clk) begin
    if (rst) begin
      calStart_q <= 1'h0;
    end else if (clkEn) begin
      calStart_q <= calCmdTaken;
    end
  end

  // calibration mode: default while grounded or after a reset request
  always_ff @(posedge clk) begin
    if (rst) begin
      calDefault_q <= 1'h1;
    end else if (clkEn) begin
      if (calPinGrounded) begin
        calDefault_q <= 1'h1;
      end else if (calResetReq) begin
        calDefault_q <= 1'h1;
      end else if (calCmdTaken) begin
        calDefault_q <= 1'h0;
      end
    end
  end

  // read address decode; write-only and unknown addresses read as zero
  always_comb begin
    if (addrHit(modeAddress, ADDR_REV_FIRST)) begin
      readSel = RSEL_REV1;
    end else if (addrHit(modeAddress, ADDR_REV_SECOND)) begin
      readSel = RSEL_REV2;
    end else if (addrHit(modeAddress, ADDR_DEV_INFO)) begin
      readSel = RSEL_INFO;
    end else if (addrHit(modeAddress, ADDR_VEND_TEST)) begin
      readSel = RSEL_VENDOR;
    end else begin
      readSel = RSEL_ZERO;
    end
  end

  // read byte multiplexer; identifiers are constants, so writes leave them alone
  always_comb begin
    readData_d = READ_ZERO;
    case (readSel)
      RSEL_REV1: begin
        readData_d = REV_FIRST;
      end
      RSEL_REV2: begin
        readData_d = REV_SECOND;
      end
      RSEL_INFO: begin
        readData_d = devInfo(devType, devDensity, devWidth);
      end
      RSEL_VENDOR: begin
        readData_d = vendorTest_q;
      end
      default: begin
        readData_d = READ_ZERO;
      end
    endcase
  end

  // read strobe answered one cycle after the command
  always_ff @(posedge clk) begin
    if (rst) begin
      readValid_q <= 1'h0;
    end else if (clkEn) begin
      readValid_q <= modeRegReadCmd;
    end
  end

  // read data register, zero outside the answer cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      readData_q <= READ_ZERO;
    end else if (clkEn) begin
      readData_q <= modeRegReadCmd ? readData_d : READ_ZERO;
    end
  end

  // read answer outputs
  assign readData              = readData_q;
  assign readValid             = readValid_q;

  // calibration outputs
  assign calResetPulse         = calReset_q;
  assign calStartPulse         = calStart_q;
  assign calDefaultMode        = calDefault_q;

  // termination and vendor test outputs
  assign dataBusTermination    = dqTermOut_q;
  assign commandBusTermination = caTermOut_q;
  assign vendorTest            = vendorTest_q;

endmodule
`default_nettype wire

// File: verif/dmrb_monitor.sv
// checker for the mode register read path
`timescale 1ns/100ps
`default_nettype none
module dmrb_monitor
  import dmrb_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       clkEn,
  input wire logic       modeRegReadCmd,
  input wire logic [5:0] modeAddress,
  input wire logic [7:0] readData,
  input wire logic       readValid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd; modeRegReadCmd && clkEn; endsequence
  property p_id1; s_rd ##0 modeAddress == 6'h06 |=> readData == REV_FIRST_DEF; endproperty
  a_id1: assert property (p_id1) else $error("bad id one");
  property p_id2; s_rd ##0 modeAddress == 6'h07 |=> readData == REV_SECOND_DEF; endproperty
  a_id2: assert property (p_id2) else $error("bad id two");
  property p_lo; s_rd ##0 modeAddress < 6'h06 |=> readData == 8'h00; endproperty
  a_lo: assert property (p_lo) else $error("low read not zero");
  property p_hi; s_rd ##0 modeAddress > 6'h09 |=> readData == 8'h00; endproperty
  a_hi: assert property (p_hi) else $error("high read not zero");
  property p_rv; s_rd |=> readValid; endproperty
  a_rv: assert property (p_rv) else $error("no valid");
  property p_src; readValid && $past(clkEn) |-> $past(modeRegReadCmd); endproperty
  a_src: assert property (p_src) else $error("stray valid");
  property p_gap; !readValid |-> readData == 8'h00; endproperty
  a_gap: assert property (p_gap) else $error("data off cycle");
  property p_idle; !modeRegReadCmd && clkEn |=> !readValid; endproperty
  a_idle: assert property (p_idle) else $error("valid without read");
endmodule
bind dmrb_mode_registers dmrb_monitor i_dmrb_monitor (.clk(clk), .rst(rst), .clkEn(clkEn),
  .modeRegReadCmd(modeRegReadCmd), .modeAddress(modeAddress), .readData(readData),
  .readValid(readValid));
`default_nettype wire

// File: verif/dmrb_ctrl_model.sv
// controller model issuing mode register commands
`timescale 1ns/100ps
`default_nettype none
module dmrb_ctrl_model
  import dmrb_pkg::*;
(
  input  wire logic       req,
  input  wire logic       wr,
  input  wire logic [5:0] a,
  input  wire logic [7:0] d,
  output logic            wCmd,
  output logic            rCmd,
  output logic      [5:0] mA,
  output logic      [7:0] op
);
  // strobes only in a request, idle lines show the inverse
  assign wCmd = req && wr;
  assign rCmd = req && !wr;
  assign mA   = req ? a : ~a;
  assign op   = !req ? ~d : (a == ADDR_VEND_TEST) ? VEND_RESET : d;
endmodule
`default_nettype wire

// File: verif/dmrb_mode_registers_tb.sv
// self-checking bench for the mode register bank
`timescale 1ns/100ps
`default_nettype none
module dmrb_mode_registers_tb
  import dmrb_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, req = 1'b0, wr = 1'b0, ws = 1'b0, os = 1'b0, cc = 1'b0;
  logic en = 1'b1, gnd = 1'b0;
  logic wC, rC, rv, cR, cS, cD;
  logic [2:0] dq, ca;
  logic [5:0] a = 6'h00, mA;
  logic [7:0] d = 8'h00, st = 8'h00, op, rd, vt, t, cp [2] = '{8'h00, 8'h00};
  logic [31:0] s = 32'h00010F8D;
  int badCount = 0, numChecks = 0;
  dmrb_ctrl_model i_dmrb_ctrl_model (.req(req), .wr(wr), .a(a), .d(d), .wCmd(wC), .rCmd(rC),
    .mA(mA), .op(op));
  dmrb_mode_registers i_dmrb_mode_registers (.clk(clk), .rst(rst), .clkEn(en),
    .modeRegWriteCmd(wC), .modeRegReadCmd(rC), .modeAddress(mA), .operandBits(op),
    .writeSetPointSelect(ws), .operatingSetPointSelect(os), .calPinGrounded(gnd),
    .calCommand(cc), .devType(st[1:0]), .devDensity(st[5:2]), .devWidth(st[7:6]),
    .readData(rd), .readValid(rv), .calResetPulse(cR), .calStartPulse(cS), .calDefaultMode(cD),
    .dataBusTermination(dq), .commandBusTermination(ca), .vendorTest(vt));
  initial forever #25 clk = ~clk;
  function automatic logic [31:0] nx(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [2:0] tm(logic [2:0] c);
    return (c == TERM_RESERVED) ? TERM_RESET : c;
  endfunction
  function automatic logic [7:0] ex(logic [5:0] x);
    return x == 6'h06 ? REV_FIRST_DEF : x == 6'h07 ? REV_SECOND_DEF : x == 6'h08 ? st : 8'h00;
  endfunction
  task automatic chk(logic [7:0] e, logic [7:0] v);
    numChecks++;
    if (v !== e) begin
      badCount++;
      $display("CHECK FAILED %0t exp %h got %h", $time, e, v);
    end
  endtask
  task automatic giveVerdict;
    $display("checks %0d errors %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one request or calibration command, taken at the second edge
  task automatic go(logic r, logic w, logic c, logic [5:0] x, logic [7:0] y);
    @(posedge clk);
    {req, wr, cc, a, d} <= {r, w, c, x, y};
    {st, ws, os} <= s[9:0];
    @(posedge clk);
    {req, cc} <= 2'h0;
    #1;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 40; i++) begin
      s = nx(s);
      t = (i < 6) ? 8'(i + 6) : {2'h0, s[15:10]};
      if (t < 8'h0A) go(1'b1, 1'b1, 1'b0, t[5:0], s[31:24]);
      go(1'b1, 1'b0, 1'b0, t[5:0], 8'h00);
      chk(ex(t[5:0]), rd);
    end
    // a read while the clock enable is low must not be answered
    @(posedge clk);
    en <= 1'b0;
    go(1'b1, 1'b0, 1'b0, ADDR_REV_FIRST, 8'h00);
    chk(READ_ZERO, rd);
    @(posedge clk);
    en <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      s = nx(s);
      t = {1'b0, 3'(~i), 1'b0, 3'(i)};
      go(1'b1, 1'b1, 1'b0, ADDR_TERM_CTRL, t);
      cp[s[1]] = t;
      repeat (2) @(posedge clk);
      #1;
      t = cp[s[0]];
      chk({1'b0, tm(t[6:4]), 1'b0, tm(t[2:0])}, {1'b0, ca, 1'b0, dq});
    end
    @(posedge clk);
    gnd <= 1'b1;
    go(1'b0, 1'b1, 1'b1, 6'h00, 8'h00);
    chk(8'h01, {6'h00, cS, cD});
    @(posedge clk);
    gnd <= 1'b0;
    go(1'b0, 1'b0, 1'b1, 6'h00, 8'h00);
    chk(8'h02, {6'h00, cS, cD});
    go(1'b1, 1'b1, 1'b0, ADDR_CAL_RESET, 8'h01);
    chk(8'h03, {6'h00, cR, cD});
    chk(VEND_RESET, vt);
    giveVerdict;
  end
endmodule
`default_nettype wire
